// ==== rtl/txfcr_consts.vh ====
`ifndef TXFCR_CONSTS_VH
`define TXFCR_CONSTS_VH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define TXFCR_ADDR_W 9
`define TXFCR_OFF_SA5 9'h16a
`define TXFCR_OFF_SA6 9'h16b
`define TXFCR_OFF_SA7 9'h16c
`define TXFCR_OFF_SA8 9'h16d
`define TXFCR_OFF_MMODE 9'h180
`define TXFCR_OFF_CTRL1 9'h181
`define TXFCR_OFF_CTRL2 9'h182
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define TXFCR_RST_REG 8'h00
// ------------------------------------------------------------
// Master mode fields
// ------------------------------------------------------------
`define TXFCR_MM_FRAMER_ENABLE 7
`define TXFCR_MM_INIT 6
`define TXFCR_MM_SOFTRST 1
`define TXFCR_MM_STD 0
`define TXFCR_MM_MASK 8'hc3
// ------------------------------------------------------------
// Control register 1 fields
// ------------------------------------------------------------
`define TXFCR_C1_B7 7
`define TXFCR_C1_B6 6
`define TXFCR_C1_B5 5
`define TXFCR_C1_B4 4
`define TXFCR_C1_B3 3
`define TXFCR_C1_B2 2
`define TXFCR_C1_AIS 1
`define TXFCR_C1_B0 0
// ------------------------------------------------------------
// Control register 2 fields
// ------------------------------------------------------------
`define TXFCR_C2_DL_SEL 7
`define TXFCR_C2_SLC 6
`define TXFCR_C2_PER_CORR 4
`define TXFCR_C2_BURST_CORR 3
`define TXFCR_C2_D4RAI 2
`define TXFCR_C2_DENSITY 1
`define TXFCR_C2_ZS 0
`define TXFCR_C2_MASK 8'hdf
// ------------------------------------------------------------
// Corruption timing, counted in framing bits
// ------------------------------------------------------------
`define TXFCR_FBIT_PERIOD 8'd128
`define TXFCR_BURST_LEN 2'd3
`endif

// ==== rtl/txfcr_top.v ====
`timescale 1ns/1ns
module txfcr_top (
    input wire CLK,
    input wire RST,
    input wire [8:0] ADDR,
    input wire [7:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [7:0] RDATA,
    input wire MF_BOUNDARY,
    input wire [3:0] FRAME_NUM,
    input wire FBIT_SLOT,
    input wire SLOT26_BIT1,
    output wire CORE_RESET,
    output wire FRAMER_RUN,
    output wire LOW_POWER,
    output wire E1_MODE,
    output reg [3:0] SA58_BITS,
    output wire SA58_VALID,
    output reg [7:0] T1_CTRL,
    output reg [7:0] E1_CTRL,
    output reg [5:0] T1_CTRL2,
    output reg FBIT_CORRUPT,
    output reg CHBLK_FORCE,
    output reg LINE_ALL_ONES
);
`include "txfcr_consts.vh"

// ------------------------------------------------------------
// Host registers
// ------------------------------------------------------------
reg [7:0] sa5_q, sa6_q, sa7_q, sa8_q;
reg [7:0] mm_q, c1_q, c2_q;
reg [7:0] c1_act_q, c2_act_q, sa5_act_q, sa6_act_q, sa7_act_q, sa8_act_q;
reg run_q, std_act_q;

// Soft reset acts as a level and also clears the bank except itself
wire srst = mm_q[`TXFCR_MM_SOFTRST];

function [2:0] odd_frame_idx;
    input [3:0] fr;
    begin
        odd_frame_idx = fr[3:1];
    end
endfunction

always @(posedge CLK or posedge RST) begin
    if (RST) begin
        sa5_q <= `TXFCR_RST_REG;
        sa6_q <= `TXFCR_RST_REG;
        sa7_q <= `TXFCR_RST_REG;
        sa8_q <= `TXFCR_RST_REG;
        mm_q <= `TXFCR_RST_REG;
        c1_q <= `TXFCR_RST_REG;
        c2_q <= `TXFCR_RST_REG;
    end else begin
        if (WR && ADDR == `TXFCR_OFF_MMODE) begin
            mm_q <= WDATA & `TXFCR_MM_MASK;
        end else if (srst) begin
            mm_q <= mm_q & (8'h01 << `TXFCR_MM_SOFTRST);
        end
        if (srst) begin
            sa5_q <= `TXFCR_RST_REG;
            sa6_q <= `TXFCR_RST_REG;
            sa7_q <= `TXFCR_RST_REG;
            sa8_q <= `TXFCR_RST_REG;
            c1_q <= `TXFCR_RST_REG;
            c2_q <= `TXFCR_RST_REG;
        end else if (WR) begin
            case (ADDR)
                `TXFCR_OFF_SA5: sa5_q <= WDATA;
                `TXFCR_OFF_SA6: sa6_q <= WDATA;
                `TXFCR_OFF_SA7: sa7_q <= WDATA;
                `TXFCR_OFF_SA8: sa8_q <= WDATA;
                `TXFCR_OFF_CTRL1: c1_q <= WDATA;
                `TXFCR_OFF_CTRL2: c2_q <= WDATA & `TXFCR_C2_MASK;
                default: ;
            endcase
        end
    end
end

// ------------------------------------------------------------
// Read path; registered data, unmapped reads return zero
// ------------------------------------------------------------
always @(posedge CLK or posedge RST) begin
    if (RST) begin
        RDATA <= 8'h00;
    end else if (RD) begin
        case (ADDR)
            `TXFCR_OFF_SA5: RDATA <= sa5_q;
            `TXFCR_OFF_SA6: RDATA <= sa6_q;
            `TXFCR_OFF_SA7: RDATA <= sa7_q;
            `TXFCR_OFF_SA8: RDATA <= sa8_q;
            `TXFCR_OFF_MMODE: RDATA <= mm_q;
            `TXFCR_OFF_CTRL1: RDATA <= c1_q;
            `TXFCR_OFF_CTRL2: RDATA <= c2_q;
            default: RDATA <= 8'h00;
        endcase
    end
end

// ------------------------------------------------------------
// Start-up and boundary shadowing
// ------------------------------------------------------------
// Settings are copied at multiframe boundaries so a frame never sees a
// half-written configuration.
always @(posedge CLK or posedge RST) begin
    if (RST) begin
        run_q <= 1'b0;
        std_act_q <= 1'b0;
        c1_act_q <= `TXFCR_RST_REG;
        c2_act_q <= `TXFCR_RST_REG;
        sa5_act_q <= `TXFCR_RST_REG;
        sa6_act_q <= `TXFCR_RST_REG;
        sa7_act_q <= `TXFCR_RST_REG;
        sa8_act_q <= `TXFCR_RST_REG;
    end else if (srst) begin
        run_q <= 1'b0;
        std_act_q <= 1'b0;
        c1_act_q <= `TXFCR_RST_REG;
        c2_act_q <= `TXFCR_RST_REG;
        sa5_act_q <= `TXFCR_RST_REG;
        sa6_act_q <= `TXFCR_RST_REG;
        sa7_act_q <= `TXFCR_RST_REG;
        sa8_act_q <= `TXFCR_RST_REG;
    end else begin
        if (!run_q && mm_q[`TXFCR_MM_INIT] && mm_q[`TXFCR_MM_FRAMER_ENABLE]) begin
            run_q <= 1'b1;
            std_act_q <= mm_q[`TXFCR_MM_STD];
            c1_act_q <= c1_q;
            c2_act_q <= c2_q;
            sa5_act_q <= sa5_q;
            sa6_act_q <= sa6_q;
            sa7_act_q <= sa7_q;
            sa8_act_q <= sa8_q;
        end else if (run_q && !mm_q[`TXFCR_MM_FRAMER_ENABLE]) begin
            run_q <= 1'b0;
        end else if (run_q && MF_BOUNDARY) begin
            c1_act_q <= c1_q;
            c2_act_q <= c2_q;
            sa5_act_q <= sa5_q;
            sa6_act_q <= sa6_q;
            sa7_act_q <= sa7_q;
            sa8_act_q <= sa8_q;
        end
    end
end

assign CORE_RESET = srst;
assign FRAMER_RUN = run_q;
assign LOW_POWER = ~mm_q[`TXFCR_MM_FRAMER_ENABLE];
assign E1_MODE = std_act_q;
assign SA58_VALID = run_q & std_act_q & FRAME_NUM[0];

// ------------------------------------------------------------
// Decoded controls per mode
// ------------------------------------------------------------
always @(posedge CLK or posedge RST) begin
    if (RST) begin
        SA58_BITS <= 4'h0;
        T1_CTRL <= 8'h00;
        E1_CTRL <= 8'h00;
        T1_CTRL2 <= 6'h00;
        CHBLK_FORCE <= 1'b0;
        LINE_ALL_ONES <= 1'b0;
    end else begin
        SA58_BITS <= {sa5_act_q[odd_frame_idx(FRAME_NUM)],
                      sa6_act_q[odd_frame_idx(FRAME_NUM)],
                      sa7_act_q[odd_frame_idx(FRAME_NUM)],
                      sa8_act_q[odd_frame_idx(FRAME_NUM)]};
        if (run_q && !std_act_q) begin
            T1_CTRL[7] <= c1_act_q[`TXFCR_C1_B7];
            T1_CTRL[6] <= c1_act_q[`TXFCR_C1_B6];
            T1_CTRL[5] <= c1_act_q[`TXFCR_C1_B5];
            // Signaling and stuffing only matter with zero suppression on
            T1_CTRL[4] <= c1_act_q[`TXFCR_C1_B4] & c2_act_q[`TXFCR_C2_ZS];
            T1_CTRL[3] <= c1_act_q[`TXFCR_C1_B3] & c2_act_q[`TXFCR_C2_ZS];
            T1_CTRL[2] <= c1_act_q[`TXFCR_C1_B2];
            T1_CTRL[1] <= c2_act_q[`TXFCR_C2_ZS];
            T1_CTRL[0] <= c1_act_q[`TXFCR_C1_B0];
            T1_CTRL2 <= {c2_act_q[`TXFCR_C2_DL_SEL],
                         c2_act_q[`TXFCR_C2_SLC], c2_act_q[`TXFCR_C2_D4RAI],
                         c2_act_q[`TXFCR_C2_DENSITY], c2_act_q[`TXFCR_C2_PER_CORR],
                         c2_act_q[`TXFCR_C2_BURST_CORR]};
        end else begin
            T1_CTRL <= 8'h00;
            T1_CTRL2 <= 6'h00;
        end
        if (run_q && std_act_q) begin
            E1_CTRL[7] <= c1_act_q[`TXFCR_C1_B7];
            E1_CTRL[6] <= c1_act_q[`TXFCR_C1_B6];
            E1_CTRL[5] <= c1_act_q[`TXFCR_C1_B5];
            // Register-sourced Si is refused while slot 0 passes through
            E1_CTRL[4] <= c1_act_q[`TXFCR_C1_B4] & ~c1_act_q[`TXFCR_C1_B7];
            E1_CTRL[3] <= c1_act_q[`TXFCR_C1_B3];
            E1_CTRL[2] <= c1_act_q[`TXFCR_C1_B2];
            E1_CTRL[1] <= c1_act_q[`TXFCR_C1_AIS];
            E1_CTRL[0] <= c1_act_q[`TXFCR_C1_B0];
        end else begin
            E1_CTRL <= 8'h00;
        end
        CHBLK_FORCE <= run_q & std_act_q & c1_act_q[`TXFCR_C1_B5] & SLOT26_BIT1;
        LINE_ALL_ONES <= run_q & c1_act_q[`TXFCR_C1_AIS];
    end
end

// ------------------------------------------------------------
// Framing-bit corruption
// ------------------------------------------------------------
// Burst arms on the register bit, not the shadow, so a quick toggle is kept.
reg burst_prev_q;
reg [1:0] burst_q;
reg [7:0] fcnt_q;
wire per_en = run_q & ~std_act_q & c2_act_q[`TXFCR_C2_PER_CORR];
wire burst_rise = c2_q[`TXFCR_C2_BURST_CORR] & ~burst_prev_q;
wire per_hit = per_en && FBIT_SLOT && fcnt_q == (`TXFCR_FBIT_PERIOD - 8'd1);

always @(posedge CLK or posedge RST) begin
    if (RST) begin
        burst_prev_q <= 1'b0;
        burst_q <= 2'd0;
        fcnt_q <= 8'd0;
        FBIT_CORRUPT <= 1'b0;
    end else if (srst) begin
        burst_prev_q <= 1'b0;
        burst_q <= 2'd0;
        fcnt_q <= 8'd0;
        FBIT_CORRUPT <= 1'b0;
    end else begin
        burst_prev_q <= c2_q[`TXFCR_C2_BURST_CORR];
        if (!per_en) begin
            fcnt_q <= 8'd0;
        end else if (FBIT_SLOT) begin
            fcnt_q <= per_hit ? 8'd0 : fcnt_q + 8'd1;
        end
        if (burst_rise && run_q && !std_act_q) begin
            burst_q <= `TXFCR_BURST_LEN;
        end else if (FBIT_SLOT && burst_q != 2'd0) begin
            burst_q <= burst_q - 2'd1;
        end
        FBIT_CORRUPT <= FBIT_SLOT & (per_hit | (burst_q != 2'd0));
    end
end

endmodule // txfcr_top

// ==== testbench/txfcr_checker.sv ====
`timescale 1ns/1ns
// ----------------
// Port checks
// ----------------
module txfcr_checker (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [3:0] FRAME_NUM,
    input wire logic FBIT_SLOT,
    input wire logic SLOT26_BIT1,
    input wire logic CORE_RESET,
    input wire logic FRAMER_RUN,
    input wire logic LOW_POWER,
    input wire logic E1_MODE,
    input wire logic SA58_VALID,
    input wire logic [7:0] T1_CTRL,
    input wire logic [7:0] E1_CTRL,
    input wire logic FBIT_CORRUPT,
    input wire logic CHBLK_FORCE,
    input wire logic LINE_ALL_ONES
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    property p_dis; LOW_POWER |=> !FRAMER_RUN; endproperty
    a_dis: assert property (p_dis) else $error("run kept while disabled");
    property p_start; $rose(FRAMER_RUN) |-> !LOW_POWER; endproperty
    a_start: assert property (p_start) else $error("start while disabled");
    property p_srst; CORE_RESET |=> !FRAMER_RUN; endproperty
    a_srst: assert property (p_srst) else $error("run during soft reset");
    property p_srst_out; CORE_RESET [*3] |-> T1_CTRL == 8'h00 && E1_CTRL == 8'h00; endproperty
    a_srst_out: assert property (p_srst_out) else $error("controls live in reset");
    property p_mode; E1_MODE && $past(E1_MODE) |-> T1_CTRL == 8'h00; endproperty
    a_mode: assert property (p_mode) else $error("T1 controls in E1 mode");
    property p_sa; SA58_VALID |-> E1_MODE && FRAMER_RUN && FRAME_NUM[0]; endproperty
    a_sa: assert property (p_sa) else $error("spare bits valid wrongly");
    property p_chblk; CHBLK_FORCE |-> $past(SLOT26_BIT1) && $past(E1_MODE); endproperty
    a_chblk: assert property (p_chblk) else $error("block force off slot");
    property p_corr; FBIT_CORRUPT |-> $past(FBIT_SLOT); endproperty
    a_corr: assert property (p_corr) else $error("corrupt without framing bit");
    property p_ais; LINE_ALL_ONES |-> $past(FRAMER_RUN); endproperty
    a_ais: assert property (p_ais) else $error("all ones while stopped");
endmodule // txfcr_checker
bind txfcr_top txfcr_checker chk (.*);

// ==== testbench/test_tx_framer_control_regs.sv ====
`timescale 1ns/1ns
`include "txfcr_consts.vh"
module test_tx_framer_control_regs;
    reg CLK = 1'b0;
    reg RST = 1'b1;
    reg [8:0] ADDR = 9'h000;
    reg [7:0] WDATA = 8'h00;
    reg WR = 1'b0, RD = 1'b0, MF_BOUNDARY = 1'b0, FBIT_SLOT = 1'b0, SLOT26_BIT1 = 1'b0;
    reg [3:0] FRAME_NUM = 4'h0;
    wire [7:0] RDATA, T1_CTRL, E1_CTRL;
    wire [5:0] T1_CTRL2;
    wire [3:0] SA58_BITS;
    wire CORE_RESET, FRAMER_RUN, LOW_POWER, E1_MODE, SA58_VALID;
    wire FBIT_CORRUPT, CHBLK_FORCE, LINE_ALL_ONES;
    integer n_fail = 0, checks_done = 0, seed = 84246, cyc = 0, hits = 0, h0, i;
    reg [7:0] c1, c2;
    reg [7:0] sa [0:3];
    txfcr_top dut (.*);
    always #4 CLK = ~CLK;
    // Cut a hang short; the whole sequence needs under 2000 cycles
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        hits <= hits + (FBIT_CORRUPT === 1'b1);
        if (cyc == 5000) begin
            n_fail = n_fail + 1;
            stop_test;
        end
    end
    // ----------------
    // Tasks
    // ----------------
    task stop_test;
        begin
            $display("fails %0d checks %0d", n_fail, checks_done);
            if (n_fail == 0 && checks_done > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task tick(input integer n);
        begin
            repeat (n) @(posedge CLK);
            #1;
        end
    endtask
    // Strobes drop for a cycle between transfers so none is set twice in one step
    task wr(input [8:0] a, input [7:0] d);
        begin
            ADDR = a;
            WDATA = d;
            WR = 1'b1;
            tick(1);
            WR = 1'b0;
            tick(1);
        end
    endtask
    task rd(input [8:0] a, input [7:0] e);
        begin
            ADDR = a;
            RD = 1'b1;
            tick(1);
            RD = 1'b0;
            chk(RDATA, e);
            tick(1);
        end
    endtask
    task slots(input integer n);
        begin
            repeat (n) begin
                FBIT_SLOT = 1'b1;
                tick(1);
                FBIT_SLOT = 1'b0;
                tick(1);
            end
            tick(2);
        end
    endtask
    function [7:0] t1x(input [7:0] a, input [7:0] b);
        t1x = {a[7:5], a[4] & b[0], a[3] & b[0], a[2], b[0], a[0]};
    endfunction
    function [7:0] e1x(input [7:0] a);
        e1x = {a[7:5], a[4] & ~a[7], a[3:0]};
    endfunction
    // ----------------
    // Sequence
    // ----------------
    initial begin
        tick(10);
        RST = 1'b0;
        for (i = 0; i < 7; i = i + 1)
            rd(i < 4 ? 9'h16a + i : 9'h17c + i, 8'h00);
        rd(9'h100, 8'h00);
        for (i = 0; i < 4; i = i + 1) begin
            sa[i] = $random(seed);
            wr(9'h16a + i, sa[i]);
            rd(9'h16a + i, sa[i]);
        end
        c1 = $random(seed);
        wr(`TXFCR_OFF_CTRL1, c1);
        rd(`TXFCR_OFF_CTRL1, c1);
        c2 = ($random(seed) & 8'he7) | 8'h01;
        wr(`TXFCR_OFF_CTRL2, c2);
        rd(`TXFCR_OFF_CTRL2, c2 & `TXFCR_C2_MASK);
        wr(`TXFCR_OFF_MMODE, 8'hbd);
        rd(`TXFCR_OFF_MMODE, 8'h81);
        chk(FRAMER_RUN, 8'h00);
        wr(`TXFCR_OFF_MMODE, 8'hc0);
        tick(2);
        chk(FRAMER_RUN, 8'h01);
        chk(E1_MODE, 8'h00);
        chk(T1_CTRL, t1x(c1, c2));
        chk(T1_CTRL2, {c2[7], c2[6], c2[2], c2[1], c2[4], c2[3]});
        chk(LINE_ALL_ONES, c1[1]);
        // New settings wait for the multiframe boundary
        wr(`TXFCR_OFF_CTRL1, ~c1);
        tick(2);
        chk(T1_CTRL, t1x(c1, c2));
        MF_BOUNDARY = 1'b1;
        tick(1);
        MF_BOUNDARY = 1'b0;
        tick(2);
        chk(T1_CTRL, t1x(~c1, c2));
        h0 = hits;
        wr(`TXFCR_OFF_CTRL2, c2 | 8'h08);
        slots(5);
        chk(hits - h0, 8'd3);
        wr(`TXFCR_OFF_CTRL2, c2 | 8'h10);
        MF_BOUNDARY = 1'b1;
        tick(1);
        MF_BOUNDARY = 1'b0;
        h0 = hits;
        slots(256);
        chk(hits - h0, 8'd2);
        wr(`TXFCR_OFF_MMODE, 8'hc2);
        tick(2);
        chk(FRAMER_RUN, 8'h00);
        chk(CORE_RESET, 8'h01);
        rd(`TXFCR_OFF_CTRL1, 8'h00);
        rd(`TXFCR_OFF_MMODE, 8'h02);
        wr(`TXFCR_OFF_MMODE, 8'h00);
        for (i = 0; i < 4; i = i + 1) begin
            sa[i] = $random(seed);
            wr(9'h16a + i, sa[i]);
        end
        c1 = $random(seed) | 8'h20;
        wr(`TXFCR_OFF_CTRL1, c1);
        wr(`TXFCR_OFF_MMODE, 8'h81);
        wr(`TXFCR_OFF_MMODE, 8'hc1);
        tick(2);
        chk(E1_MODE, 8'h01);
        chk(E1_CTRL, e1x(c1));
        chk(LINE_ALL_ONES, c1[1]);
        for (i = 0; i < 16; i = i + 1) begin
            FRAME_NUM = i;
            tick(1);
            chk(SA58_VALID, i % 2);
            if (i % 2)
                chk(SA58_BITS, {sa[0][i/2], sa[1][i/2], sa[2][i/2], sa[3][i/2]});
        end
        SLOT26_BIT1 = 1'b1;
        tick(1);
        SLOT26_BIT1 = 1'b0;
        chk(CHBLK_FORCE, 8'h01);
        wr(`TXFCR_OFF_MMODE, 8'h41);
        chk(LOW_POWER, 8'h01);
        chk(FRAMER_RUN, 8'h00);
        stop_test;
    end
endmodule // test_tx_framer_control_regs
